// *** design/udp_gpio.sv ***
`timescale 1ns/1ps
`default_nettype none
module udp_gpio
  import udp_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic clk, // 40 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused protection
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // unused protection
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [NPIN-1:0] pinIn, // pad levels, pins 4..58
  output logic [NPIN-1:0] pinOut, // pad drive values
  output logic [NPIN-1:0] pinOe, // pad drive enables
  input wire logic pushButtonInput, // button pad, input only
  input wire logic opticalReceivePin, // receive pad level for routing
  input wire logic realEnergyPulse, // compute engine pulse
  input wire logic reactiveEnergyPulse, // compute engine pulse
  input wire logic auxPulseX, // compute engine pulse
  input wire logic auxPulseY, // compute engine pulse
  input wire logic eeClkOut, // eeprom engine clock drive
  input wire logic eeDataOut, // eeprom engine data drive
  input wire logic eeDataOe, // eeprom engine data enable
  output logic eeDataIn, // synchronized eeprom data pad
  output logic [31:0] pinFunctionSelectMap, // 1 = pin owned by display
  output logic counterZeroClock, // routed counter 0 clock level
  output logic counterOneClock, // routed counter 1 clock level
  output logic highPriorityPinIrq, // routed edge pulse
  output logic lowPriorityPinIrq, // routed edge pulse
  output logic irq // enabled sticky status level
);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [7:0][31:0] seg;
    logic [31:0] funcMap;
    logic [19:0] dirLo;
    logic [31:0] dataLo;
    logic [2:0] dedDir;
    logic [2:0] dedVal;
    logic [4:0] ctrl;
    logic [26:0] rsel;
    logic [1:0] irqSt;
    logic [1:0] irqEn;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [1:0] aux1;
    logic [1:0] aux2;
    logic [NSRC-1:0] prev;
    logic [NPIN-1:0] pOut;
    logic [NPIN-1:0] pOe;
    logic cnt0;
    logic cnt1;
    logic hiIrq;
    logic loIrq;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } udp_state_t;

  udp_state_t st_ff;
  udp_state_t nxt_st;

  // decode reads address bits 7..2, so a narrower bus cannot reach the segment window
  if (ADDR_W < 8 || ADDR_W > 16)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 16");
  end

  // byte-strobed merge keeps untouched lanes, so segment bits survive
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // ************************************************
  // bus handshakes
  // ************************************************
  // write taken only with address and data both offered
  assign awready = awvalid && wvalid && !st_ff.bvalid;
  assign wready = awready;
  assign arready = !st_ff.rvalid;

  logic wrGo;
  logic rdGo;
  logic [7:0] wa;
  logic [7:0] ra;
  assign wrGo = awvalid && wvalid && !st_ff.bvalid;
  assign rdGo = arvalid && !st_ff.rvalid;
  assign wa = {awaddr[7:2], 2'b00};
  assign ra = {araddr[7:2], 2'b00};

  // ************************************************
  // next state
  // ************************************************
  always_comb
  begin
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] val;
    logic [NPIN-1:0] lcd;
    logic [NSRC-1:0] src;
    logic [2:0] sel;
    logic [31:0] rd;
    logic hit;
    logic [1:0] ev;
    int k;
    dir = '0;
    val = '0;
    lcd = '0;
    src = '0;
    sel = RS_NONE;
    rd = RST_WORD;
    hit = 1'b0;
    ev = 2'b00;
    k = 0;
    nxt_st = st_ff;

    // two-stage synchronizers; stage one is read by stage two only
    nxt_st.sync1 = pinIn;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.aux1 = {opticalReceivePin, pushButtonInput};
    nxt_st.aux2 = st_ff.aux1;

    // per-pin direction and data source
    for (int i = 0; i < NPIN; i++)
    begin
      k = i + PIN_BASE;
      if (k < SEG_FIRST)
      begin
        dir[i] = st_ff.dirLo[i];
        val[i] = st_ff.dataLo[i];
      end
      else if (k < DED_FIRST)
      begin
        dir[i] = st_ff.seg[(k-SEG_FIRST)/4][8*((k-SEG_FIRST)%4)+SEG_DIR_BIT];
        lcd[i] = st_ff.funcMap[k-SEG_FIRST];
        if (k < SEG_DATA_FIRST)
          val[i] = st_ff.dataLo[i];
        else
          val[i] = st_ff.seg[(k-SEG_FIRST)/4][8*((k-SEG_FIRST)%4)+SEG_DATA_BIT];
      end
      else
      begin
        dir[i] = st_ff.dedDir[k-DED_FIRST];
        val[i] = st_ff.dedVal[k-DED_FIRST];
      end
    end

    // pulse outputs replace data on enabled output pins
    if (st_ff.ctrl[CTRL_REAL])
      val[6-PIN_BASE] = realEnergyPulse;
    if (st_ff.ctrl[CTRL_REACT])
      val[7-PIN_BASE] = reactiveEnergyPulse;
    if (st_ff.ctrl[CTRL_AUXX])
      val[8-PIN_BASE] = auxPulseX;
    if (st_ff.ctrl[CTRL_AUXY])
      val[9-PIN_BASE] = auxPulseY;
    nxt_st.pOut = val;
    nxt_st.pOe = dir & ~lcd;
    // eeprom engine takes pins 4 and 5 over
    if (st_ff.ctrl[CTRL_EESEL])
    begin
      nxt_st.pOut[1:0] = {eeDataOut, eeClkOut};
      nxt_st.pOe[1:0] = {eeDataOe, 1'b1};
    end

    // resource routing on synchronized pad levels, driven or not
    src = {st_ff.aux2[1], st_ff.sync2[6:0], st_ff.aux2[0]};
    nxt_st.prev = src;
    nxt_st.cnt0 = 1'b0;
    nxt_st.cnt1 = 1'b0;
    nxt_st.hiIrq = 1'b0;
    nxt_st.loIrq = 1'b0;
    for (int j = 0; j < NSRC; j++)
    begin
      sel = st_ff.rsel[3*j +: 3];
      // codes none and reserved route nowhere; all hits OR together
      unique case (sel)
        RS_CNT0: nxt_st.cnt0 = nxt_st.cnt0 | src[j];
        RS_CNT1: nxt_st.cnt1 = nxt_st.cnt1 | src[j];
        RS_HI_RISE: nxt_st.hiIrq = nxt_st.hiIrq | (src[j] & ~st_ff.prev[j]);
        RS_LO_RISE: nxt_st.loIrq = nxt_st.loIrq | (src[j] & ~st_ff.prev[j]);
        RS_HI_FALL: nxt_st.hiIrq = nxt_st.hiIrq | (~src[j] & st_ff.prev[j]);
        RS_LO_FALL: nxt_st.loIrq = nxt_st.loIrq | (~src[j] & st_ff.prev[j]);
        default: ;
      endcase
    end
    ev = {nxt_st.loIrq, nxt_st.hiIrq};

    // register writes
    if (wrGo)
    begin
      hit = 1'b1;
      if (wa >= OFS_SEG_BASE && wa <= OFS_SEG_LAST)
        nxt_st.seg[wa[4:2]] = merge(st_ff.seg[wa[4:2]], wdata, wstrb);
      else
        unique case (wa)
          OFS_CTRL: nxt_st.ctrl = 5'(merge(32'(st_ff.ctrl), wdata, wstrb));
          OFS_FUNC_MAP: nxt_st.funcMap = merge(st_ff.funcMap, wdata, wstrb);
          OFS_DIR_LO: nxt_st.dirLo = 20'(merge(32'(st_ff.dirLo), wdata, wstrb));
          OFS_DATA_LO: nxt_st.dataLo = merge(st_ff.dataLo, wdata, wstrb);
          OFS_RSEL: nxt_st.rsel = 27'(merge(32'(st_ff.rsel), wdata, wstrb));
          OFS_IRQ_EN: nxt_st.irqEn = 2'(merge(32'(st_ff.irqEn), wdata, wstrb));
          OFS_IRQ_CLR:
            if (wstrb[0])
              nxt_st.irqSt = st_ff.irqSt & ~wdata[1:0];
          OFS_DED_DIR, OFS_DED_VAL:
            for (int d = 0; d < 3; d++)
              if (wstrb[d])
              begin
                if (wa == OFS_DED_DIR)
                  nxt_st.dedDir[d] = wdata[8*d+DED_DIR_BIT];
                else
                  nxt_st.dedVal[d] = wdata[8*d+DED_VAL_BIT];
              end
          default: hit = 1'b0;
        endcase
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      nxt_st.bvalid = 1'b0;
    // hardware set wins over a same-cycle clear
    nxt_st.irqSt = nxt_st.irqSt | ev;

    // register reads; data bits return the pad level
    if (rdGo)
    begin
      hit = 1'b1;
      if (ra >= OFS_SEG_BASE && ra <= OFS_SEG_LAST)
      begin
        rd = st_ff.seg[ra[4:2]];
        for (int b = 0; b < 4; b++)
          if (SEG_FIRST + 4*ra[4:2] + b >= SEG_DATA_FIRST)
            rd[8*b+SEG_DATA_BIT] = st_ff.sync2[SEG_FIRST-PIN_BASE+4*ra[4:2]+b];
      end
      else
        unique case (ra)
          OFS_CTRL: rd = 32'(st_ff.ctrl);
          OFS_FUNC_MAP: rd = st_ff.funcMap;
          OFS_DIR_LO: rd = 32'(st_ff.dirLo);
          OFS_DATA_LO: rd = st_ff.sync2[31:0];
          OFS_RSEL: rd = 32'(st_ff.rsel);
          OFS_IRQ_STAT: rd = 32'(st_ff.irqSt);
          OFS_IRQ_EN: rd = 32'(st_ff.irqEn);
          OFS_DED_DIR, OFS_DED_VAL:
            for (int d = 0; d < 3; d++)
              if (ra == OFS_DED_DIR)
                rd[8*d+DED_DIR_BIT] = st_ff.dedDir[d];
              else
                rd[8*d+DED_VAL_BIT] = st_ff.sync2[DED_FIRST-PIN_BASE+d];
          default: hit = 1'b0;
        endcase
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      nxt_st.rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      nxt_st.rvalid = 1'b0;
  end

  // ************************************************
  // registers
  // ************************************************
  // everything clears, so every pin starts as an input
  always_ff @(posedge clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ************************************************
  // outputs
  // ************************************************
  // the button has no driver at all, so it never appears here
  assign pinOut = st_ff.pOut;
  assign pinOe = st_ff.pOe;
  assign eeDataIn = st_ff.sync2[1];
  assign pinFunctionSelectMap = st_ff.funcMap;
  assign counterZeroClock = st_ff.cnt0;
  assign counterOneClock = st_ff.cnt1;
  assign highPriorityPinIrq = st_ff.hiIrq;
  assign lowPriorityPinIrq = st_ff.loIrq;
  assign irq = |(st_ff.irqSt & st_ff.irqEn);
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rresp = st_ff.rresp;
  assign rdata = st_ff.rdata;

endmodule // udp_gpio
`default_nettype wire

// *** design/udp_pkg.sv ***
package udp_pkg;
  // pin vector index 0 is the fourth digital pin; the top entry is the last dedicated pin
  localparam int NPIN = 55;
  localparam int PIN_BASE = 4;
  localparam int SEG_FIRST = 24;
  localparam int SEG_DATA_FIRST = 36;
  localparam int DED_FIRST = 56;
  localparam int NSRC = 9;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FUNC_MAP = 8'h04;
  localparam logic [7:0] OFS_DIR_LO = 8'h08;
  localparam logic [7:0] OFS_DATA_LO = 8'h0c;
  localparam logic [7:0] OFS_DED_DIR = 8'h10;
  localparam logic [7:0] OFS_DED_VAL = 8'h14;
  localparam logic [7:0] OFS_RSEL = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;
  localparam logic [7:0] OFS_SEG_BASE = 8'h40;
  localparam logic [7:0] OFS_SEG_LAST = 8'h5c;
  // field positions
  localparam int SEG_DIR_BIT = 3;
  localparam int SEG_DATA_BIT = 0;
  localparam int DED_DIR_BIT = 7;
  localparam int DED_VAL_BIT = 4;
  localparam int CTRL_REAL = 0;
  localparam int CTRL_REACT = 1;
  localparam int CTRL_AUXX = 2;
  localparam int CTRL_AUXY = 3;
  localparam int CTRL_EESEL = 4;
  // resource selector codes
  localparam logic [2:0] RS_NONE = 3'h0;
  localparam logic [2:0] RS_CNT0 = 3'h2;
  localparam logic [2:0] RS_CNT1 = 3'h3;
  localparam logic [2:0] RS_HI_RISE = 3'h4;
  localparam logic [2:0] RS_LO_RISE = 3'h5;
  localparam logic [2:0] RS_HI_FALL = 3'h6;
  localparam logic [2:0] RS_LO_FALL = 3'h7;
  // reset word and response codes
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** tb/udp_gpio_chk_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module udp_gpio_chk
  import udp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic awvalid, // aw valid
  input wire logic wvalid, // w valid
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [1:0] bresp, // b resp
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic [NPIN-1:0] pinOe, // pad enables
  input wire logic [31:0] pinFunctionSelectMap, // display owned
  input wire logic highPriorityPinIrq // routed pulse
);
  // ****************
  // bus and pad properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst; $fell(srst) |-> pinOe == '0 && !bvalid && !rvalid; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_bwait; awvalid && wvalid && !bvalid |=> bvalid; endproperty
  a_bwait: assert property (p_bwait) else $error("no write answer");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bdone; bvalid && bready |=> !bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated");
  property p_rwait; arvalid && arready |=> rvalid; endproperty
  a_rwait: assert property (p_rwait) else $error("no read answer");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_err; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  // one cycle grace: the pad enable lags the map register by one edge
  property p_map; (pinOe[51:20] & pinFunctionSelectMap & $past(pinFunctionSelectMap)) == 32'h0; endproperty
  a_map: assert property (p_map) else $error("display pin driven");
  c_err: cover property (bvalid && bresp == RESP_SLVERR);
  c_irq: cover property (highPriorityPinIrq);
  c_ded: cover property (|pinOe[54:52]);
endmodule // udp_gpio_chk
bind udp_gpio udp_gpio_chk i_udp_gpio_chk (
  .clk(clk), .srst(srst), .awvalid(awvalid), .wvalid(wvalid), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .pinOe(pinOe), .pinFunctionSelectMap(pinFunctionSelectMap),
  .highPriorityPinIrq(highPriorityPinIrq)
);
`default_nettype wire

// *** tb/udp_pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module udp_pad_model
  import udp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic [NPIN-1:0] pinOut, // drive values
  input wire logic [NPIN-1:0] pinOe, // drive enables
  output logic [NPIN-1:0] pinIn // pad levels
);
  // ****************
  // external pads
  // ****************
  logic [NPIN-1:0] float_ff = '0;
  // released pads wander, so a stale level never passes for a driven one
  always @(posedge clk) float_ff <= ~float_ff;
  // a driven pad reads back its own level, so routing can watch outputs
  assign pinIn = (pinOe & pinOut) | (~pinOe & float_ff);
endmodule // udp_pad_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import udp_pkg::*;
;
  // ****************
  // stimulus and checks
  // ****************
  logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, pinFunctionSelectMap, r, d;
  logic [3:0] wstrb = 4'h0;
  logic pushButtonInput = 1'b0, opticalReceivePin = 1'b0, eeClkOut = 1'b0, eeDataOut = 1'b0, eeDataOe = 1'b0;
  logic realEnergyPulse = 1'b0, reactiveEnergyPulse = 1'b0, auxPulseX = 1'b0, auxPulseY = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, eeDataIn, irq, counterZeroClock, counterOneClock;
  logic highPriorityPinIrq, lowPriorityPinIrq;
  logic [1:0] bresp, rresp;
  logic [NPIN-1:0] pinIn, pinOut, pinOe;
  logic [33:0] rq [$];
  logic [33:0] e;
  logic [1:0] bq [$];
  logic [7:0] rstOfs [8] = '{OFS_CTRL, OFS_FUNC_MAP, OFS_DIR_LO, OFS_DED_DIR, OFS_RSEL, OFS_IRQ_STAT, OFS_IRQ_EN, OFS_SEG_BASE};
  int n_fail = 0, checked = 0, hiN = 0, loN = 0, c0N = 0, c1N = 0;
  udp_gpio i_udp_gpio (
    .clk(clk), .srst(srst), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pushButtonInput(pushButtonInput), .opticalReceivePin(opticalReceivePin),
    .realEnergyPulse(realEnergyPulse), .reactiveEnergyPulse(reactiveEnergyPulse), .auxPulseX(auxPulseX),
    .auxPulseY(auxPulseY), .eeClkOut(eeClkOut), .eeDataOut(eeDataOut), .eeDataOe(eeDataOe),
    .eeDataIn(eeDataIn), .pinFunctionSelectMap(pinFunctionSelectMap), .counterZeroClock(counterZeroClock),
    .counterOneClock(counterOneClock), .highPriorityPinIrq(highPriorityPinIrq),
    .lowPriorityPinIrq(lowPriorityPinIrq), .irq(irq)
  );
  udp_pad_model i_udp_pad_model (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait: sample settled at the falling edge, take at the next rising edge
  // w picks the answer watched: 0 awready, 1 bvalid, 2 arready, 3 rvalid
  task automatic hs(input int w);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
      s = (w == 0) ? awready : (w == 1) ? bvalid : (w == 2) ? arready : rvalid;
    end
    if (s !== 1'b1)
    begin
      n_fail++;
      results();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] st = 4'hf, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    bq.push_back(er);
    awaddr <= a;
    wdata <= dt;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hs(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs(2);
    arvalid <= 1'b0;
    hs(3);
    rready <= 1'b0;
  endtask
  // covers write, pad sync and routing latency with margin
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask
  // each response is matched to the oldest note
  always @(posedge clk)
  begin
    if (rvalid && rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk(rdata, e[31:0]);
      chk({30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (bvalid && bready && bq.size() > 0)
      chk({30'h0, bresp}, {30'h0, bq.pop_front()});
  end
  // routed outputs are tallied where settled
  always @(negedge clk)
  begin
    hiN += int'(highPriorityPinIrq);
    loN += int'(lowPriorityPinIrq);
    c0N += int'(counterZeroClock);
    c1N += int'(counterOneClock);
  end
  initial
  begin
    r = $urandom(32'h59f51da0);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    foreach (rstOfs[i]) rd(rstOfs[i], RST_WORD);
    chk({31'h0, |pinOe}, 32'h0);
    wr(8'h2c, 32'hffffffff, 4'hf, RESP_SLVERR);
    rd(8'h2c, 32'h0, RESP_SLVERR);
    r = $urandom & 32'h000fffff;
    d = $urandom;
    wr(OFS_DIR_LO, r);
    wr(OFS_DATA_LO, d);
    wr(OFS_SEG_BASE, 32'h08);
    wr(OFS_SEG_BASE + 8'h0c, 32'h09090909);
    settle();
    chk(32'(pinOe[19:0]), r);
    chk(32'(pinOut[19:0] & r[19:0]), d & r);
    chk({30'h0, pinOe[20], pinOut[20]}, {30'h0, 1'b1, d[20]});
    chk(32'({pinOe[35:32], pinOut[35:32]}), 32'hff);
    rd(OFS_SEG_BASE + 8'h0c, 32'h09090909);
    wr(OFS_SEG_BASE + 8'h0c, 32'h0, 4'h2);
    settle();
    chk(32'(pinOe[35:32]), 32'hd);
    wr(OFS_FUNC_MAP, 32'h1000);
    settle();
    chk(32'(pinOe[35:32]), 32'hc);
    chk(pinFunctionSelectMap, 32'h1000);
    wr(OFS_DED_DIR, 32'h007f8080);
    wr(OFS_DED_VAL, 32'h00ef1010);
    settle();
    chk(32'({pinOe[54:52], pinOut[53:52]}), 32'h0f);
    wr(OFS_DIR_LO, 32'h3c);
    wr(OFS_CTRL, 32'hf);
    repeat (4)
    begin
      r = $urandom;
      @(posedge clk) {auxPulseY, auxPulseX, reactiveEnergyPulse, realEnergyPulse} <= r[3:0];
      settle();
      chk(32'(pinOut[5:2]), 32'(r[3:0]));
    end
    wr(OFS_CTRL, 32'h10);
    @(posedge clk) {eeClkOut, eeDataOut, eeDataOe} <= 3'b011;
    settle();
    chk(32'({pinOe[1:0], pinOut[1:0]}), 32'he);
    chk({31'h0, eeDataIn}, 32'h1);
    wr(OFS_CTRL, 32'h0);
    settle();
    chk(32'(pinOut[5:2]), 32'(d[5:2]));
    for (int c = 0; c < 8; c++)
    begin
      wr(OFS_RSEL, 32'(c));
      settle();
      {hiN, loN, c0N, c1N} = '0;
      @(posedge clk) pushButtonInput <= 1'b1;
      settle();
      @(posedge clk) pushButtonInput <= 1'b0;
      settle();
      chk(32'({hiN == 1, loN == 0}), 32'({c == 4 || c == 6, c != 5 && c != 7}));
      chk(32'({loN == 1, c0N > 0, c1N > 0}), 32'({c == 5 || c == 7, c == 2, c == 3}));
    end
    chk({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_EN, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_RSEL, 32'h02000400);
    wr(OFS_DIR_LO, 32'h4);
    @(posedge clk) opticalReceivePin <= 1'b1;
    settle();
    chk({31'h0, counterZeroClock}, 32'h1);
    @(posedge clk) opticalReceivePin <= 1'b0;
    wr(OFS_DATA_LO, 32'h4);
    settle();
    chk({31'h0, counterZeroClock}, 32'h1);
    // every noted bus answer must have been seen
    chk(32'(rq.size() + bq.size()), 32'h0);
    results();
  end
endmodule // tb_top
`default_nettype wire
